// ### hdl/reset_irq_pin_control.sv
// reset release sequencing, interrupt request detection and crystal pin reuse
module reset_irq_pin_control
	import pin_ctrl_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic test_rstn_i,
	input  wire logic ext_irq_request_pin_i,
	input  wire logic irq_mode_fall_i,
	input  wire logic irq_ack_i,
	input  wire logic boot_mode_select_pin_i,
	input  wire logic relax_osc_sel_i,
	input  wire logic [3:2] port_b_out_i,
	input  wire logic [3:2] port_b_dir_i,
	input  wire logic crystal_in_pin_i,
	input  wire logic crystal_out_drive_i,
	output logic      core_rstn_o,
	output logic      debug_rstn_o,
	output logic      boot_mode_o,
	output logic      irq_req_o,
	output logic      crystal_in_pin_o,
	output logic      crystal_in_pin_oe_o,
	output logic      crystal_out_pin_o,
	output logic      crystal_out_pin_oe_o,
	output logic [3:2] port_b_in_o
);
	rst_state_t           state_q, state_d;
	logic [RST_CNT_W-1:0] cnt_q;
	logic                 core_rstn_q;
	logic                 boot_q;
	logic                 irq_q;
	logic                 dbg_q;
	logic                 in_o_q, in_oe_q, out_o_q, out_oe_q;
	logic [3:2]           pb_in_q;
	logic                 irq_level, irq_fall;
	logic                 xin_level;

	// rstn_i is the reset pin; asynchronous assertion, counted release
	wire cnt_done = (cnt_q == RST_CNT_W'(RST_RELEASE_CYC - 1));
	wire core_rstn_d = (state_q == RST_COUNT) && cnt_done ? 1'b1 : core_rstn_q;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			RST_HOLD:  state_d = RST_COUNT;
			RST_COUNT: if (cnt_done) state_d = RST_RUN;
			RST_RUN:   state_d = RST_RUN;
			default:   state_d = RST_HOLD;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q     <= RST_HOLD;
			cnt_q       <= RST_CNT_RESET;
			core_rstn_q <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			cnt_q       <= (state_q == RST_COUNT) ? cnt_q + 1'b1 : cnt_q;
			core_rstn_q <= core_rstn_d;
		end
	end

	// boot mode latched on the first edge after release; no pin value under async reset
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			boot_q <= BOOT_MODE_RESET;
		else if (state_q == RST_HOLD)
			boot_q <= boot_mode_select_pin_i;
	end

	// debug logic follows only the test reset, never the device reset
	always_ff @(posedge core_clk_i or negedge test_rstn_i)
	begin
		if (!test_rstn_i)
			dbg_q <= 1'b0;
		else
			dbg_q <= 1'b1;
	end

	pin_sync3 u_irq_sync
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (ext_irq_request_pin_i),
		.level_o    (irq_level),
		.fall_o     (irq_fall)
	);

	wire irq_set = (irq_mode_fall_i == IRQ_MODE_FALL) ? irq_fall : 1'b0;
	wire irq_d   = (irq_mode_fall_i == IRQ_MODE_LEVEL) ? !irq_level
	             : (irq_set || (irq_q && !irq_ack_i));

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_q <= 1'b0;
		else
			irq_q <= core_rstn_q && irq_d;
	end

	// crystal input pad is asynchronous to the core clock when read as port B bit 2
	pin_sync3 u_xin_sync
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (crystal_in_pin_i),
		.level_o    (xin_level),
		.fall_o     ()
	);

	// port B bits 2 and 3 only when the relaxation oscillator runs the chip
	wire gp    = relax_osc_sel_i && core_rstn_q;
	wire b2_oe = gp && port_b_dir_i[2];
	wire b3_oe = gp && port_b_dir_i[3];

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			in_o_q   <= 1'b0;
			in_oe_q  <= 1'b0;
			out_o_q  <= 1'b0;
			out_oe_q <= 1'b0;
			pb_in_q  <= 2'h0;
		end
		else
		begin
			in_o_q     <= port_b_out_i[2];
			in_oe_q    <= b2_oe;
			out_o_q    <= gp ? port_b_out_i[3] : crystal_out_drive_i;
			out_oe_q   <= gp ? b3_oe : 1'b1;
			pb_in_q[2] <= gp && xin_level;
			pb_in_q[3] <= gp && crystal_out_drive_i;
		end
	end

	assign core_rstn_o          = core_rstn_q;
	assign debug_rstn_o         = dbg_q;
	assign boot_mode_o          = boot_q;
	assign irq_req_o            = irq_q;
	assign crystal_in_pin_o     = in_o_q;
	assign crystal_in_pin_oe_o  = in_oe_q;
	assign crystal_out_pin_o    = out_o_q;
	assign crystal_out_pin_oe_o = out_oe_q;
	assign port_b_in_o          = pb_in_q;

	AST_RST_HELD: assert property (@(posedge core_clk_i) !rstn_i |-> !core_rstn_o)
		else $error("core reset released while reset pin low");
	AST_RST_COUNT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(state_q == RST_COUNT) |-> !core_rstn_o [*8])
		else $error("core reset released too early");
	AST_RST_DONE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(state_q == RST_COUNT) |-> ##[1:40] core_rstn_o)
		else $error("core reset never released");
	AST_BOOT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		state_q == RST_HOLD |=> boot_mode_o == $past(boot_mode_select_pin_i))
		else $error("boot mode not captured");
	AST_DBG: assert property (@(posedge core_clk_i) disable iff (!test_rstn_i)
		$past(dbg_q) |-> debug_rstn_o)
		else $error("debug logic reset by device reset");
	AST_IRQ_LVL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		core_rstn_q && irq_mode_fall_i == IRQ_MODE_LEVEL && !irq_level |=> irq_req_o)
		else $error("level request missed");
	AST_IRQ_FALL: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		core_rstn_q && irq_mode_fall_i && irq_fall |=> irq_req_o)
		else $error("falling edge request missed");
	AST_B3: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!relax_osc_sel_i |=> crystal_out_pin_oe_o)
		else $error("crystal output not driven");
	AST_B2: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!relax_osc_sel_i |=> !crystal_in_pin_oe_o)
		else $error("crystal input driven without relaxation oscillator");

	// request, reset and pin mux details
	AST_IRQ_RST: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!core_rstn_q |=> !irq_req_o)
		else $error("request raised while core held in reset");
	AST_IRQ_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		core_rstn_q && irq_mode_fall_i && irq_req_o && !irq_ack_i |=> irq_req_o)
		else $error("edge request dropped without acknowledge");
	AST_IRQ_ACK: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		irq_mode_fall_i && irq_ack_i && !irq_fall |=> !irq_req_o)
		else $error("edge request survived acknowledge");
	AST_BOOT_KEEP: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		state_q != RST_HOLD |=> $stable(boot_mode_o))
		else $error("boot mode changed after capture");
	AST_RST_ONLY_COUNT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(core_rstn_o) |-> $past(state_q) == RST_COUNT)
		else $error("core reset released outside the count");
	AST_CORE_RUN: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		state_q == RST_RUN |-> core_rstn_o)
		else $error("core reset low in run state");
	AST_B2_OE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		relax_osc_sel_i && core_rstn_q |=> crystal_in_pin_oe_o == $past(port_b_dir_i[2]))
		else $error("port B bit 2 direction not followed");
	AST_B3_OE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		relax_osc_sel_i && core_rstn_q |=> crystal_out_pin_oe_o == $past(port_b_dir_i[3]))
		else $error("port B bit 3 direction not followed");
	AST_B3_CRYSTAL_OUT_PIN: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!relax_osc_sel_i |=> crystal_out_pin_o == $past(crystal_out_drive_i))
		else $error("crystal output not carrying oscillator drive");
	AST_PB_IDLE: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!relax_osc_sel_i |=> port_b_in_o == 2'h0)
		else $error("port B reads nonzero in crystal mode");

	CV_RELEASE: cover property (@(posedge core_clk_i) $rose(core_rstn_o));
	CV_IRQ_FALL: cover property (@(posedge core_clk_i) irq_fall && irq_mode_fall_i);
	CV_GPIO: cover property (@(posedge core_clk_i) crystal_in_pin_oe_o);
	CV_LEVEL_REQ: cover property (@(posedge core_clk_i) irq_req_o && !irq_mode_fall_i);
	CV_DEBUG_ONLY: cover property (@(posedge core_clk_i) !rstn_i && debug_rstn_o);
endmodule

// ### hdl/pin_ctrl_pkg.sv
// constants and types for the reset, interrupt request and crystal pin control block
// How it works
// - interrupt request pin synchronised before use
// - request detects low level or falling edge
// - reset pin low holds controller in reset
// - boot mode pin captured at reset release
// - internal reset released after fixed clock count
// - device reset alone leaves debug logic running
// - crystal input doubles as port B bit 2
// - crystal output doubles as port B bit 3
package pin_ctrl_pkg;
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned RST_RELEASE_CYC  = 32;
	localparam int unsigned RST_CNT_W        = 6;
	localparam logic [5:0]  RST_CNT_RESET    = 6'h00;
	localparam logic [2:0]  SYNC_RESET       = 3'h7;
	localparam logic        IRQ_MODE_LEVEL   = 1'b0;
	localparam logic        IRQ_MODE_FALL    = 1'b1;
	localparam logic        BOOT_MODE_RESET  = 1'b0;

	typedef enum logic [1:0]
	{
		RST_HOLD    = 2'b00,
		RST_COUNT   = 2'b01,
		RST_RUN     = 2'b10
	} rst_state_t;
endpackage

// ### hdl/pin_sync3.sv
// three-stage pin synchroniser; a change counts when stages two and three agree
module pin_sync3
	import pin_ctrl_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      fall_o
);
	logic [2:0] sync_q;
	logic       level_q;
	logic       fall_q;
	wire        agree = (sync_q[1] == sync_q[2]);

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync_q  <= SYNC_RESET;
			level_q <= 1'b1;
			fall_q  <= 1'b0;
		end
		else
		begin
			sync_q  <= {sync_q[1:0], pin_i};
			if (agree)
				level_q <= sync_q[2];
			fall_q  <= agree && level_q && !sync_q[2];
		end
	end

	assign level_o = level_q;
	assign fall_o  = fall_q;
endmodule

// ### verification/board_model.sv
// board reset source and external interrupting device
module board_model
(
	input  wire logic clk_i,
	output logic      rstn_o,
	output logic      test_rstn_o,
	output logic      irq_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		rstn_o = 1'b0;
		test_rstn_o = 1'b0;
		irq_pin_o = 1'b1;
	end
	// a full reset pulls both lines; a debug session pulls the device line alone
	task automatic hold_reset(input bit full);
		@(negedge clk_i);
		rstn_o <= 1'b0;
		test_rstn_o <= !full;
	endtask
	task automatic release_reset();
		@(negedge clk_i);
		rstn_o <= 1'b1;
		test_rstn_o <= 1'b1;
	endtask
	task automatic drive_irq(input logic lvl, input int cyc);
		@(negedge clk_i);
		irq_pin_o <= lvl;
		repeat (cyc) @(negedge clk_i);
	endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the reset, interrupt request and crystal pin control block
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench
	import pin_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk_i, rstn_i, test_rstn_i, irq_pin, irq_mode_fall_i, irq_ack_i;
	logic       boot_mode_select_pin_i, relax_osc_sel_i, crystal_in_pin_i, crystal_out_drive_i;
	logic [3:2] port_b_out_i, port_b_dir_i;
	wire        core_rstn_o, debug_rstn_o, boot_mode_o, irq_req_o;
	wire        crystal_in_pin_o, crystal_in_pin_oe_o, crystal_out_pin_o, crystal_out_pin_oe_o;
	wire  [3:2] port_b_in_o;
	wire  [3:2] oe_v  = {crystal_out_pin_oe_o, crystal_in_pin_oe_o};
	wire  [3:2] drv_v = {crystal_out_pin_o, crystal_in_pin_o};
	wire  [3:2] pad_v = {crystal_out_drive_i, crystal_in_pin_i};
	int         err_total, cmp_count, cyc_n, exp_req;
	logic       boot_v;
	board_model board (.clk_i(core_clk_i), .rstn_o(rstn_i), .test_rstn_o(test_rstn_i),
		.irq_pin_o(irq_pin));
	reset_irq_pin_control DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.test_rstn_i(test_rstn_i), .ext_irq_request_pin_i(irq_pin),
		.irq_mode_fall_i(irq_mode_fall_i), .irq_ack_i(irq_ack_i),
		.boot_mode_select_pin_i(boot_mode_select_pin_i), .relax_osc_sel_i(relax_osc_sel_i),
		.port_b_out_i(port_b_out_i), .port_b_dir_i(port_b_dir_i),
		.crystal_in_pin_i(crystal_in_pin_i), .crystal_out_drive_i(crystal_out_drive_i),
		.core_rstn_o(core_rstn_o), .debug_rstn_o(debug_rstn_o), .boot_mode_o(boot_mode_o),
		.irq_req_o(irq_req_o), .crystal_in_pin_o(crystal_in_pin_o),
		.crystal_in_pin_oe_o(crystal_in_pin_oe_o), .crystal_out_pin_o(crystal_out_pin_o),
		.crystal_out_pin_oe_o(crystal_out_pin_oe_o), .port_b_in_o(port_b_in_o));
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	// cut a hang short well past the expected run length
	always @(posedge core_clk_i)
	begin
		cyc_n++;
		if (cyc_n == 3000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	initial
	begin
		{irq_mode_fall_i, irq_ack_i, relax_osc_sel_i, crystal_in_pin_i} = 4'h0;
		crystal_out_drive_i = 1'b0;
		port_b_out_i = 2'h0;
		port_b_dir_i = 2'h0;
		void'($urandom(95823));
		boot_v = 1'($urandom);
		boot_mode_select_pin_i = boot_v;
		board.hold_reset(1'b1);
		repeat (7) @(negedge core_clk_i);
		board.release_reset();
		@(negedge core_clk_i);
		boot_mode_select_pin_i = ~boot_v;
		repeat (31) @(negedge core_clk_i);
		`CHK("core_rstn held", 1'b0, core_rstn_o)
		@(negedge core_clk_i);
		`CHK("core_rstn released", 1'b1, core_rstn_o)
		`CHK("boot_mode", boot_v, boot_mode_o)
		board.hold_reset(1'b0);
		#1;
		`CHK("core_rstn async", 1'b0, core_rstn_o)
		`CHK("debug_rstn kept", 1'b1, debug_rstn_o)
		repeat (4) @(negedge core_clk_i);
		board.release_reset();
		repeat (33) @(negedge core_clk_i);
		`CHK("core_rstn again", 1'b1, core_rstn_o)
		for (int m = 0; m < 2; m++)
		begin
			irq_mode_fall_i = m[0];
			board.drive_irq(1'b0, 1);
			`CHK("irq synced", 1'b0, irq_req_o)
			repeat (5) @(negedge core_clk_i);
			`CHK("irq raised", 1'b1, irq_req_o)
			board.drive_irq(1'b1, 6);
			exp_req = m;
			`CHK("irq after pin high", exp_req[0], irq_req_o)
			irq_ack_i = 1'b1;
			@(negedge core_clk_i);
			irq_ack_i = 1'b0;
			repeat (2) @(negedge core_clk_i);
			`CHK("irq cleared", 1'b0, irq_req_o)
		end
		relax_osc_sel_i = 1'b1;
		repeat (12)
		begin
			{port_b_dir_i, port_b_out_i, crystal_in_pin_i, crystal_out_drive_i} = 6'($urandom);
			repeat (6) @(negedge core_clk_i);
			`CHK("gpio oe", port_b_dir_i, oe_v)
			`CHK("gpio out", port_b_out_i & port_b_dir_i, drv_v & port_b_dir_i)
			`CHK("gpio in", pad_v & ~port_b_dir_i, port_b_in_o & ~port_b_dir_i)
		end
		relax_osc_sel_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		`CHK("crystal mode read", 2'h0, port_b_in_o)
		`CHK("crystal in oe", 1'b0, crystal_in_pin_oe_o)
		`CHK("crystal out oe", 1'b1, crystal_out_pin_oe_o)
		`CHK("crystal out drv", crystal_out_drive_i, crystal_out_pin_o)
		report_and_stop();
	end
endmodule
